// ==== rtl/cbf_regs.vh ====
// Constants for the compare, branch and flag-clear decode core
`ifndef CBF_REGS_VH
`define CBF_REGS_VH

// ==========================================================
// Register offsets on the APB bus
`define CBF_CTRL_OFS   8'h00
`define CBF_STAT_OFS   8'h04
`define CBF_PC_OFS     8'h08

// ==========================================================
// Control register fields and reset value
`define CBF_CTRL_RUN   0
`define CBF_CTRL_TURBO 1
`define CBF_CTRL_CHAIN 2
`define CBF_CTRL_PSCW  3
`define CBF_CTRL_RST   4'h3

// ==========================================================
// Status byte layout, reset value and its file address
`define CBF_FL_C       0
`define CBF_FL_DC      1
`define CBF_FL_Z       2
`define CBF_FL_PD      3
`define CBF_FL_TO      4
`define CBF_FL_RST     5'h18
`define CBF_STAT_ADDR  5'h03

// ==========================================================
// Cycles per word in turbo and compatibility timing
`define CBF_CYC_BASE_T 4'h1
`define CBF_CYC_BASE_C 4'h4
`define CBF_CYC_JMP_T  4'h3
`define CBF_CYC_JMP_C  4'h8

// ==========================================================
// Exact instruction words
`define CBF_OP_CLRW    12'h040
`define CBF_OP_CLRWDT  12'h004
`define CBF_OP_CLC     12'h403
`define CBF_OP_CLZ     12'h443
`define CBF_OP_SC      12'h703
`define CBF_OP_SNC     12'h603
`define CBF_OP_SZ      12'h743
`define CBF_OP_SNZ     12'h643

// ==========================================================
// Opcode field prefixes
`define CBF_PF_CLRF    7'h03
`define CBF_PF_MOVF    7'h10
`define CBF_PF_SUB     7'h04
`define CBF_PF_ADD     7'h0E
`define CBF_PF_BCLR    4'h4
`define CBF_PF_LIT     4'hC
`define CBF_PF_JMP     3'h5

`endif

// ==== rtl/cbf_file_mem.v ====
// File register memory with registered, write-first read port
`timescale 1ns/10ps
module cbf_file_mem
#(
    parameter AW = 5,
    parameter DW = 8
)
(
    input  wire          pclk,
    input  wire          ce,
    input  wire          we,
    input  wire [AW-1:0] waddr,
    input  wire [DW-1:0] wdata,
    input  wire          re,
    input  wire [AW-1:0] raddr,
    output reg  [DW-1:0] rdata_ff
);

    reg [DW-1:0] mem [0:(1<<AW)-1];

    // Write port; contents are undefined until software code writes
    always @(posedge pclk)
    begin
        if (ce && we)
            mem[waddr] <= wdata;
    end

    // Read port forwards a same-cycle write to avoid a stale operand
    always @(posedge pclk)
    begin
        if (ce && re)
        begin
            if (we && (waddr == raddr))
                rdata_ff <= wdata;
            else
                rdata_ff <= mem[raddr];
        end
    end

endmodule

// ==== rtl/cbf_alu.v ====
// Eight-bit add and subtract unit with carry and digit carry
`timescale 1ns/10ps
module cbf_alu
(
    input  wire [7:0] w_val,
    input  wire [7:0] f_val,
    input  wire       c_in,
    input  wire       chain,
    input  wire       sub,
    output wire [7:0] res,
    output wire       c_out,
    output wire       dc_out
);

    wire [7:0] b_op;
    wire       ci;
    wire [8:0] full;
    wire [4:0] low;

    // Subtract is file plus inverted work; carry means no borrow
    assign b_op = sub ? ~w_val : w_val;
    assign ci   = chain ? c_in : sub;
    assign full = {1'b0, f_val} + {1'b0, b_op} + {8'h00, ci};
    assign low  = {1'b0, f_val[3:0]} + {1'b0, b_op[3:0]} + {4'h0, ci};

    assign res    = full[7:0];
    assign c_out  = full[8];
    assign dc_out = low[4];

endmodule

// ==== rtl/cbf_core.v ====
// Decode and execute core for compare, branch and flag-clear words
//
// The APB slave port and the placing of the registers were decided locally.
`timescale 1ns/10ps
`include "cbf_regs.vh"
module cbf_core
#(
    parameter PC_W     = 11,
    parameter [10:0] RST_VEC = 11'h000
)
(
    input  wire            pclk,
    input  wire            presetn,
    input  wire            ce,
    input  wire            psel,
    input  wire            penable,
    input  wire            pwrite,
    input  wire [7:0]      paddr,
    input  wire [31:0]     pwdata,
    output reg  [31:0]     prdata_ff,
    output reg             pready_ff,
    output reg             pslverr_ff,
    output reg  [PC_W-1:0] pc_ff,
    input  wire [11:0]     pmem_data,
    output reg             wdt_restart_ff,
    output reg             psc_clear_ff
);

    // ==========================================================
    // Instruction classes
    localparam [3:0] C_NOP  = 4'h0;
    localparam [3:0] C_CLRF = 4'h1;
    localparam [3:0] C_CLRW = 4'h2;
    localparam [3:0] C_WDT  = 4'h3;
    localparam [3:0] C_BCLR = 4'h4;
    localparam [3:0] C_CLC  = 4'h5;
    localparam [3:0] C_CLZ  = 4'h6;
    localparam [3:0] C_LIT  = 4'h7;
    localparam [3:0] C_MOVF = 4'h8;
    localparam [3:0] C_SUB  = 4'h9;
    localparam [3:0] C_ADD  = 4'hA;
    localparam [3:0] C_JMP  = 4'hB;
    localparam [3:0] C_SC   = 4'hC;
    localparam [3:0] C_SNC  = 4'hD;
    localparam [3:0] C_SZ   = 4'hE;
    localparam [3:0] C_SNZ  = 4'hF;

    // Sequencer states
    localparam [1:0] ST_FILL = 2'h0;
    localparam [1:0] ST_EXEC = 2'h1;
    localparam [1:0] ST_HALT = 2'h2;

    // ==========================================================
    // Decoder: exact words take priority over field prefixes
    function [3:0] cbf_class;
        input [11:0] iw;
        begin
            if (iw == `CBF_OP_CLRW) cbf_class = C_CLRW;
            else if (iw == `CBF_OP_CLRWDT) cbf_class = C_WDT;
            else if (iw == `CBF_OP_CLC) cbf_class = C_CLC;
            else if (iw == `CBF_OP_CLZ) cbf_class = C_CLZ;
            else if (iw == `CBF_OP_SC) cbf_class = C_SC;
            else if (iw == `CBF_OP_SNC) cbf_class = C_SNC;
            else if (iw == `CBF_OP_SZ) cbf_class = C_SZ;
            else if (iw == `CBF_OP_SNZ) cbf_class = C_SNZ;
            else if (iw[11:5] == `CBF_PF_CLRF) cbf_class = C_CLRF;
            else if (iw[11:5] == `CBF_PF_MOVF) cbf_class = C_MOVF;
            else if (iw[11:5] == `CBF_PF_SUB) cbf_class = C_SUB;
            else if (iw[11:5] == `CBF_PF_ADD) cbf_class = C_ADD;
            else if (iw[11:8] == `CBF_PF_BCLR) cbf_class = C_BCLR;
            else if (iw[11:8] == `CBF_PF_LIT) cbf_class = C_LIT;
            else if (iw[11:9] == `CBF_PF_JMP) cbf_class = C_JMP;
            else cbf_class = C_NOP;
        end
    endfunction

    // ==========================================================
    // State
    reg [1:0]  st_ff;
    reg [11:0] ir_ff;
    reg [3:0]  cnt_ff;
    reg        skip_ff;
    reg [7:0]  w_ff;
    reg [4:0]  fl_ff;
    reg [3:0]  ctrl_ff;
    reg [7:0]  nxt_w;
    reg [4:0]  nxt_fl;
    reg        fm_we;
    reg [7:0]  fm_wdata;
    reg        skip_cond;
    reg        jmp_take;
    reg        wdt_hit;
    reg        z_force;
    reg [3:0]  len;
    wire [3:0] cls;
    wire       turbo;
    wire       run;
    wire       done;
    wire       exec;
    wire       load;
    wire [4:0] faddr;
    wire [7:0] fm_rdata;
    wire [7:0] fval;
    wire [7:0] bclr_mask;
    wire [7:0] alu_res;
    wire       alu_c;
    wire       alu_dc;
    assign cls   = cbf_class(ir_ff);
    assign turbo = ctrl_ff[`CBF_CTRL_TURBO];
    assign run   = ctrl_ff[`CBF_CTRL_RUN];
    assign faddr = ir_ff[4:0];
    // Status byte answers its own file address, always current
    assign fval = (faddr == `CBF_STAT_ADDR) ? {3'h0, fl_ff} : fm_rdata;
    // Word length; a skipped jump costs only a base word
    always @*
    begin
        if ((cls == C_JMP) && !skip_ff)
            len = turbo ? `CBF_CYC_JMP_T - 4'h1
                        : `CBF_CYC_JMP_C - 4'h1;
        else
            len = turbo ? `CBF_CYC_BASE_T
                        : `CBF_CYC_BASE_C;
    end

    assign done = ce && (st_ff == ST_EXEC) && (cnt_ff == len - 4'h1);
    assign exec = done && !skip_ff;
    assign load = ce && ((st_ff == ST_FILL) || (done && !jmp_take));
    // ==========================================================
    // Bit-clear mask, one lane per bit
    genvar gi;
    generate
        for (gi = 0; gi < 8; gi = gi + 1)
        begin : g_mask
            localparam integer BI = gi;
            assign bclr_mask[gi] = (ir_ff[7:5] != BI[2:0]);
        end
    endgenerate
    cbf_alu u_alu
    (
        .w_val  (w_ff),
        .f_val  (fval),
        .c_in   (fl_ff[`CBF_FL_C]),
        .chain  (ctrl_ff[`CBF_CTRL_CHAIN]),
        .sub    (cls == C_SUB),
        .res    (alu_res),
        .c_out  (alu_c),
        .dc_out (alu_dc)
    );
    cbf_file_mem #(.AW(5), .DW(8)) u_fmem
    (
        .pclk     (pclk),
        .ce       (ce),
        .we       (fm_we),
        .waddr    (faddr),
        .wdata    (fm_wdata),
        .re       (load),
        .raddr    (pmem_data[4:0]),
        .rdata_ff (fm_rdata)
    );

    // ==========================================================
    // Execute: effects of the current word on its last cycle
    always @*
    begin
        nxt_w     = w_ff;
        nxt_fl    = fl_ff;
        fm_we     = 1'b0;
        fm_wdata  = 8'h00;
        skip_cond = 1'b0;
        jmp_take  = 1'b0;
        wdt_hit   = 1'b0;
        z_force   = 1'b0;
        if (exec)
        begin
            case (cls)
                C_CLRF:
                begin
                    fm_we   = 1'b1;
                    z_force = 1'b1;
                end
                C_CLRW:
                begin
                    nxt_w           = 8'h00;
                    nxt_fl[`CBF_FL_Z] = 1'b1;
                end
                C_WDT:
                begin
                    wdt_hit            = 1'b1;
                    nxt_fl[`CBF_FL_TO] = 1'b1;
                    nxt_fl[`CBF_FL_PD] = 1'b1;
                end
                C_BCLR:
                begin
                    fm_we    = 1'b1;
                    fm_wdata = fval & bclr_mask;
                end
                C_CLC:
                    nxt_fl[`CBF_FL_C] = 1'b0;
                C_CLZ:
                    nxt_fl[`CBF_FL_Z] = 1'b0;
                C_LIT:
                    nxt_w = ir_ff[7:0];
                C_MOVF:
                    nxt_w = fval;
                C_SUB, C_ADD:
                begin
                    nxt_w              = alu_res;
                    nxt_fl[`CBF_FL_C]  = alu_c;
                    nxt_fl[`CBF_FL_DC] = alu_dc;
                    nxt_fl[`CBF_FL_Z]  = (alu_res == 8'h00);
                end
                C_JMP:
                    jmp_take = 1'b1;
                C_SC:
                    skip_cond = fl_ff[`CBF_FL_C];
                C_SNC:
                    skip_cond = !fl_ff[`CBF_FL_C];
                C_SZ:
                    skip_cond = fl_ff[`CBF_FL_Z];
                C_SNZ:
                    skip_cond = !fl_ff[`CBF_FL_Z];
                default:
                    nxt_w = w_ff;
            endcase
            // A write aimed at the status byte lands in the C, DC and Z flags
            if (fm_we && (faddr == `CBF_STAT_ADDR))
                nxt_fl[2:0] = fm_wdata[2:0];
            if (z_force)
                nxt_fl[`CBF_FL_Z] = 1'b1;
        end
    end

    // ==========================================================
    // Sequencer: fetch, count cycles, skip and jump
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            st_ff          <= ST_FILL;
            ir_ff          <= 12'h000;
            cnt_ff         <= 4'h0;
            skip_ff        <= 1'b0;
            w_ff           <= 8'h00;
            fl_ff          <= `CBF_FL_RST;
            pc_ff          <= RST_VEC[PC_W-1:0];
            wdt_restart_ff <= 1'b0;
            psc_clear_ff   <= 1'b0;
        end
        else if (ce)
        begin
            wdt_restart_ff <= wdt_hit;
            psc_clear_ff   <= wdt_hit && ctrl_ff[`CBF_CTRL_PSCW];
            w_ff           <= nxt_w;
            fl_ff          <= nxt_fl;
            case (st_ff)
                ST_HALT:
                begin
                    if (run)
                        st_ff <= ST_FILL;
                end
                ST_FILL:
                begin
                    ir_ff  <= pmem_data;
                    pc_ff  <= pc_ff + {{(PC_W-1){1'b0}}, 1'b1};
                    cnt_ff <= 4'h0;
                    st_ff  <= ST_EXEC;
                end
                ST_EXEC:
                begin
                    if (!done)
                        cnt_ff <= cnt_ff + 4'h1;
                    else
                    begin
                        cnt_ff  <= 4'h0;
                        skip_ff <= skip_cond;
                        if (jmp_take)
                        begin
                            pc_ff <= {pc_ff[PC_W-1:9], ir_ff[8:0]};
                            st_ff <= run ? ST_FILL : ST_HALT;
                        end
                        else if (!run)
                            st_ff <= ST_HALT;
                        else
                        begin
                            ir_ff <= pmem_data;
                            pc_ff <= pc_ff + {{(PC_W-1){1'b0}}, 1'b1};
                        end
                    end
                end
                default:
                    st_ff <= ST_FILL;
            endcase
        end
    end

    // ==========================================================
    // APB slave: answer in the access cycle, no wait states
    reg        hit;
    reg [31:0] rd_mux;

    always @*
    begin
        hit    = 1'b1;
        rd_mux = 32'h0000_0000;
        case (paddr)
            `CBF_CTRL_OFS:
                rd_mux = {28'h000_0000, ctrl_ff};
            `CBF_STAT_OFS:
                rd_mux = {19'h0_0000, fl_ff, w_ff};
            `CBF_PC_OFS:
                rd_mux = {{(32-PC_W){1'b0}}, pc_ff};
            default:
                hit = 1'b0;
        endcase
    end

    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            prdata_ff  <= 32'h0000_0000;
            pready_ff  <= 1'b0;
            pslverr_ff <= 1'b0;
            ctrl_ff    <= `CBF_CTRL_RST;
        end
        else if (ce)
        begin
            pready_ff  <= psel && !penable;
            pslverr_ff <= psel && !penable && !hit;
            if (psel && !penable)
                prdata_ff <= pwrite ? 32'h0000_0000 : rd_mux;
            // Write lands on the completing access edge only
            if (psel && penable && pready_ff && pwrite &&
                (paddr == `CBF_CTRL_OFS))
                ctrl_ff <= pwdata[3:0];
        end
    end

endmodule

// ==== sim/cbf_checker.sv ====
// Port checker for the compare, branch and flag-clear decode core
`timescale 1ns/10ps
`include "cbf_regs.vh"
module cbf_checker
#(
    parameter PC_W = 11
)
(
    input wire            pclk,
    input wire            presetn,
    input wire            ce,
    input wire            psel,
    input wire            penable,
    input wire            pwrite,
    input wire [7:0]      paddr,
    input wire [31:0]     pwdata,
    input wire [31:0]     prdata_ff,
    input wire            pready_ff,
    input wire            pslverr_ff,
    input wire [PC_W-1:0] pc_ff,
    input wire            wdt_restart_ff,
    input wire            psc_clear_ff
);
    // ==========================================================
    // Setup decode and a mirror of the prescaler assignment bit
    wire setup  = ce && psel && !penable;
    wire mapped = paddr == `CBF_CTRL_OFS || paddr == `CBF_STAT_OFS ||
                  paddr == `CBF_PC_OFS;
    reg  pscw_ff;

    // Follows writes of the control register
    always @(posedge pclk or negedge presetn)
        if (!presetn)
            pscw_ff <= 1'h0;
        else if (ce && psel && penable && pready_ff && pwrite &&
                 paddr == `CBF_CTRL_OFS)
            pscw_ff <= pwdata[`CBF_CTRL_PSCW];

    default clocking dck @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    // ==========================================================
    // Bus and pulse relations
    AST_RDY_AFTER_SETUP: assert property (setup ##1 ce |-> pready_ff)
        else $error("no ready after setup");
    AST_RDY_PULSE: assert property (pready_ff && ce |=> !pready_ff)
        else $error("ready longer than one cycle");
    AST_ERR_UNMAP: assert property (setup && !mapped ##1 ce |->
        pslverr_ff && pready_ff && prdata_ff == 32'h0)
        else $error("unmapped access not refused");
    AST_ERR_MAPPED: assert property (setup && mapped ##1 ce |-> !pslverr_ff)
        else $error("mapped access refused");
    AST_RD_PC: assert property (setup && !pwrite && paddr == `CBF_PC_OFS
        ##1 ce |-> prdata_ff == {{(32-PC_W){1'h0}}, $past(pc_ff)})
        else $error("fetch address read wrong");
    AST_WR_ZERO: assert property (setup && pwrite ##1 ce |-> prdata_ff == 0)
        else $error("read data not zero on write");
    AST_PSC_WDT: assert property (psc_clear_ff |-> wdt_restart_ff)
        else $error("prescaler clear without restart");
    AST_PSC_MODE: assert property (wdt_restart_ff |->
        psc_clear_ff == pscw_ff)
        else $error("prescaler clear ignores assignment");
    AST_CE_FREEZE: assert property (!ce |=> $stable(pc_ff) &&
        $stable(prdata_ff))
        else $error("state moved with enable low");
endmodule

bind cbf_core cbf_checker #(.PC_W(PC_W)) i_chk
(
    .pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata_ff(prdata_ff), .pready_ff(pready_ff), .pslverr_ff(pslverr_ff),
    .pc_ff(pc_ff), .wdt_restart_ff(wdt_restart_ff),
    .psc_clear_ff(psc_clear_ff)
);

// ==== sim/cbf_pmem_model.sv ====
// Program memory model: asynchronous store of 12-bit words
`timescale 1ns/10ps
module cbf_pmem_model
#(
    parameter PC_W = 11
)
(
    input  wire [PC_W-1:0] addr,
    output wire [11:0]     data
);
    reg     [11:0] rom_ff [0:(1<<PC_W)-1];
    integer        i;

    // Unwritten words read as no-op
    initial
        for (i = 0; i < (1<<PC_W); i = i + 1)
            rom_ff[i] = 12'h000;

    // Word follows the fetch address in the same cycle
    assign data = rom_ff[addr];
endmodule

// ==== sim/test_compare_branch_flag_ops.sv ====
// Self-checking testbench for the decode core
`timescale 1ns/10ps
`include "cbf_regs.vh"
module test_compare_branch_flag_ops;
    reg          pclk;
    reg          presetn = 1'h0;
    reg          ce = 1'h1;
    reg          psel = 1'h0;
    reg          penable = 1'h0;
    reg          pwrite = 1'h0;
    reg  [7:0]   paddr = 8'h00;
    reg  [31:0]  pwdata = 32'h0;
    wire [31:0]  prdata_ff;
    wire         pready_ff;
    wire         pslverr_ff;
    wire [10:0]  pc_ff;
    wire [11:0]  pmem_data;
    wire         wdt_restart_ff;
    wire         psc_clear_ff;
    reg  [31:0]  rd;
    reg          er;
    integer      failures = 0;
    integer      checks_done = 0;
    integer      cyc = 0;
    integer      wdt_cnt = 0;
    integer      psc_cnt = 0;

    cbf_core #(.PC_W(11), .RST_VEC(11'h000)) i_dut
    (
        .pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata_ff(prdata_ff), .pready_ff(pready_ff),
        .pslverr_ff(pslverr_ff), .pc_ff(pc_ff), .pmem_data(pmem_data),
        .wdt_restart_ff(wdt_restart_ff), .psc_clear_ff(psc_clear_ff)
    );
    cbf_pmem_model #(.PC_W(11)) i_pmem (.addr(pc_ff), .data(pmem_data));

    // ==========================================================
    // Clock, cycle count and pulse counters
    initial
    begin
        pclk = 1'h0;
        forever #2 pclk = ~pclk;
    end
    always @(posedge pclk)
    begin
        cyc <= cyc + 1;
        if (ce && wdt_restart_ff)
            wdt_cnt <= wdt_cnt + 1;
        if (ce && psc_clear_ff)
            psc_cnt <= psc_cnt + 1;
    end

    // ==========================================================
    // Shared tasks
    task check(input string name, input [31:0] seen, input [31:0] exp);
        begin
            checks_done = checks_done + 1;
            if (seen !== exp)
            begin
                $display("unexpected %s expected %h seen %h", name, exp, seen);
                failures = failures + 1;
            end
        end
    endtask

    task test_done;
        begin
            $display("failures %0d checks %0d", failures, checks_done);
            if (failures == 0 && checks_done > 0)
                $display("All tests passed");
            else
                $display("Some tests failed");
            $finish;
        end
    endtask

    // One APB transfer; holds the request until ready is sampled
    task apb(input wr, input [7:0] a, input [31:0] d);
        integer n;
        begin
            @(posedge pclk);
            psel <= 1'h1;
            penable <= 1'h0;
            pwrite <= wr;
            paddr <= a;
            pwdata <= d;
            @(posedge pclk);
            penable <= 1'h1;
            n = 0;
            @(posedge pclk);
            while (pready_ff !== 1'h1 && n < 20)
            begin
                @(posedge pclk);
                n = n + 1;
            end
            if (pready_ff !== 1'h1)
                check("ready", {31'h0, pready_ff}, 32'h1);
            rd = prdata_ff;
            er = pslverr_ff;
            psel <= 1'h0;
            penable <= 1'h0;
        end
    endtask

    task wait_pc(input [10:0] a);
        integer n;
        begin
            n = 0;
            while (pc_ff !== a && n < 200)
            begin
                @(posedge pclk);
                n = n + 1;
            end
            if (n == 200)
                check("fetch address", pc_ff, a);
        end
    endtask

    // Halt, load four words plus a closing self jump, time and read back
    task run4(input [11:0] w0, w1, w2, w3, input jump_nine_bit, input [3:0] ctl,
              input [12:0] e_stat, input [7:0] e_cyc);
        reg     [10:0] b;
        reg     [10:0] t;
        integer        t0;
        begin
            apb(1'h1, `CBF_CTRL_OFS, 32'h0);
            repeat (10) @(posedge pclk);
            apb(1'h0, `CBF_PC_OFS, 32'h0);
            b = rd[10:0];
            t = b + 11'h4;
            i_pmem.rom_ff[b] = w0;
            i_pmem.rom_ff[b + 11'h1] = w1;
            i_pmem.rom_ff[b + 11'h2] = w2;
            i_pmem.rom_ff[b + 11'h3] = jump_nine_bit ? {3'h5, t[8:0]} : w3;
            i_pmem.rom_ff[t] = {3'h5, t[8:0]};
            apb(1'h1, `CBF_CTRL_OFS, {28'h0, ctl});
            wait_pc(b + 11'h1);
            t0 = cyc;
            wait_pc(b + 11'h5);
            check("cycles", cyc - t0, e_cyc);
            apb(1'h0, `CBF_STAT_OFS, 32'h0);
            check("status", rd, {19'h0, e_stat});
        end
    endtask

    // ==========================================================
    // Scenarios
    task t_regs;
        reg [10:0] p;
        begin
            apb(1'h0, `CBF_CTRL_OFS, 32'h0);
            check("ctrl reset", rd, 32'h3);
            apb(1'h0, 8'h0C, 32'h0);
            check("unmapped error", er, 32'h1);
            check("unmapped data", rd, 32'h0);
            apb(1'h1, `CBF_STAT_OFS, 32'hFFFF);
            check("status write error", er, 32'h0);
            apb(1'h0, `CBF_STAT_OFS, 32'h0);
            check("status reset", rd, 32'h1800);
            ce <= 1'h0;
            @(posedge pclk);
            p = pc_ff;
            repeat (5) @(posedge pclk);
            check("frozen pc", pc_ff, p);
            ce <= 1'h1;
        end
    endtask

    task t_clears;
        integer m;
        begin
            for (m = 0; m < 2; m = m + 1)
            begin
                run4(12'h065, 12'hC00, 12'h085, 12'h403, 1'h0, m ? 4'h1 : 4'h3,
                     13'h1E00, m ? 16 : 4);
                run4(12'h443, 12'hCA5, 12'h040, 12'h000, 1'h0, m ? 4'h1 : 4'h3,
                     13'h1E00, m ? 16 : 4);
            end
        end
    endtask

    task t_bitclr;
        run4(12'hC00, 12'h085, 12'h423, 12'h443, 1'h0, 4'h3,
             13'h1900, 4);
    endtask

    task t_add;
        run4(12'h203, 12'h1C3, 12'h000, 12'h000, 1'h0, 4'h3,
             13'h1A32, 4);
    endtask

    task t_chain;
        run4(12'hC00, 12'h083, 12'h1C5, 12'h000, 1'h0, 4'h7,
             13'h181A, 4);
    endtask

    task t_wdt;
        integer m, w, s;
        begin
            for (m = 0; m < 2; m = m + 1)
            begin
                w = wdt_cnt;
                s = psc_cnt;
                run4(12'h004, 12'h000, 12'h000, 12'h000, 1'h0, m ? 4'hB : 4'h3,
                     13'h181A, 4);
                check("restart pulses", wdt_cnt - w, 1);
                check("prescaler pulses", psc_cnt - s, m);
            end
        end
    endtask

    task t_cmp_jump;
        integer    i, m, e;
        reg [11:0] op;
        reg        lit, jump_nine_bit;
        begin
            for (i = 0; i < 8; i = i + 1)
                for (m = 0; m < 2; m = m + 1)
                begin
                    op = {3'h3, i[0], 1'h0, i[1], 6'h03};
                    lit = i[2];
                    jump_nine_bit = op[8] ^ !lit;
                    e = m ? (jump_nine_bit ? 6 : 4) : (jump_nine_bit ? 20 : 16);
                    run4({11'h600, lit}, 12'h085, op, 12'h000, 1'h1,
                         m ? 4'h3 : 4'h1, lit ? 13'h18FF : 13'h1F00,
                         e);
                end
        end
    endtask

    task t_cmp_skip;
        integer    i, m;
        reg [11:0] op;
        reg        lit, skp;
        begin
            for (i = 0; i < 8; i = i + 1)
                for (m = 0; m < 2; m = m + 1)
                begin
                    op = {3'h3, i[0], 1'h0, i[1], 6'h03};
                    lit = i[2];
                    skp = !(op[8] ^ !lit);
                    run4({11'h600, lit}, 12'h085, op, 12'hC5A, 1'h0,
                         m ? 4'h3 : 4'h1,
                         {lit ? 5'h18 : 5'h1F, skp ? {8{lit}} : 8'h5A},
                         m ? 4 : 16);
                end
        end
    endtask

    // ==========================================================
    // Main sequence and watchdog
    initial
    begin
        repeat (16) @(posedge pclk);
        presetn <= 1'h1;
        t_regs;
        t_clears;
        t_bitclr;
        t_add;
        t_chain;
        t_wdt;
        t_cmp_jump;
        t_cmp_skip;
        test_done;
    end
    initial
    begin
        #80000;
        failures = failures + 1;
        test_done;
    end
endmodule
